// >>> hdl/fsp_ctrl.sv
// fsp_ctrl: host controller driving a parallel nor flash's pins, ordered over apb
// assumes pin inputs synchronous to sys_clk_i; high-voltage levels made by outside drivers
`timescale 1ns/1ps
`include "fsp_map.svh"
module fsp_ctrl #(
  parameter int UNPROT_CYC = `FSP_WPP2_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [19:0] addr_o,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic dq_oe_n_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic rst_n_o,
  output logic hv_rst_o,
  output logic hv_a9_o,
  output logic hv_oe_o,
  output logic busy_o
);
  fsp_pkg::fsp_state_vec_t s;
  fsp_pkg::fsp_state_vec_t next_s;
  fsp_pkg::fsp_step_t cur;
  logic tdone;
  logic tok;

  localparam fsp_pkg::fsp_state_vec_t RST_VAL = '{
    st: fsp_pkg::S_IDLE, op: fsp_pkg::OP_READ, dq_oe_n: 1'b1, ce_n: 1'b1,
    oe_n: 1'b1, we_n: 1'b1, default: '0};

  // bus cycle of each order, one step at a time
  function automatic fsp_pkg::fsp_step_t seq_step(input fsp_pkg::fsp_op_t op,
      input logic [2:0] idx, input logic [19:0] a, input logic [15:0] d);
    fsp_pkg::fsp_step_t r;
    r.kind = fsp_pkg::K_W;
    r.last = 1'b0;
    r.addr = a;
    r.data = d;
    if ((idx == 3'h0) || (idx == 3'h3)) begin
      r.addr = `FSP_UNLOCK1_ADDR;
      r.data = `FSP_UNLOCK1_DATA;
    end else if ((idx == 3'h1) || (idx == 3'h4)) begin
      r.addr = `FSP_UNLOCK2_ADDR;
      r.data = `FSP_UNLOCK2_DATA;
    end
    case (op)
      fsp_pkg::OP_PROG: begin
        if (idx == 3'h2) begin
          r.addr = `FSP_UNLOCK1_ADDR;
          r.data = `FSP_CMD_PROG;
        end else if (idx == 3'h3) begin
          r.addr = a;
          r.data = d;
          r.last = 1'b1;
        end
      end
      fsp_pkg::OP_ERASE: begin
        if (idx == 3'h2) begin
          r.addr = `FSP_UNLOCK1_ADDR;
          r.data = `FSP_CMD_ERASE;
        end else if (idx == 3'h5) begin
          r.addr = a;
          r.data = `FSP_CMD_SECTOR;
          r.last = 1'b1;
        end
      end
      fsp_pkg::OP_ID: begin
        if (idx == 3'h2) begin
          r.addr = `FSP_UNLOCK1_ADDR;
          r.data = `FSP_CMD_ID;
          r.last = 1'b1;
        end
      end
      fsp_pkg::OP_ERASE_ADD: begin
        r.addr = a;
        r.data = `FSP_CMD_SECTOR;
        r.kind = (idx == 3'h1) ? fsp_pkg::K_W : fsp_pkg::K_R;
        r.last = (idx == 3'h2);
      end
      fsp_pkg::OP_POLL: begin
        r.addr = a;
        r.kind = fsp_pkg::K_R;
        r.last = (idx == 3'h3);
      end
      fsp_pkg::OP_READ, fsp_pkg::OP_VERIFY: begin
        r.addr = a;
        r.kind = fsp_pkg::K_R;
        r.last = 1'b1;
        if (op == fsp_pkg::OP_VERIFY) begin
          r.addr[`FSP_ADDRESS_BIT_ONE] = 1'b1;
        end
      end
      fsp_pkg::OP_PROTECT, fsp_pkg::OP_UNPROT: begin
        r.addr = a;
        r.addr[`FSP_ADDRESS_BIT_SIX] = (op == fsp_pkg::OP_UNPROT);
        r.kind = fsp_pkg::K_HV;
        r.last = 1'b1;
      end
      fsp_pkg::OP_RESET: begin
        r.addr = a;
        r.data = `FSP_CMD_RESET;
        r.last = 1'b1;
      end
      default: begin
        r.addr = a;
        r.data = d;
        r.last = 1'b1;
      end
    endcase
    return r;
  endfunction : seq_step

  fsp_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clk_en_i(clk_en_i),
    .load_i(s.tload),
    .val_i(s.tval),
    .done_o(tdone)
  );

  assign cur = seq_step(s.op, s.step, s.reg_addr, s.reg_data);
  assign tok = tdone && !s.tload;

  always_comb begin
    next_s = s;
    next_s.tload = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    if (psel_i && penable_i && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h00000000;
      case (paddr_i)
        `FSP_REG_CTRL: begin
          if (pwrite_i) begin
            next_s.ctrl_rst = pwdata_i[`FSP_CTRL_RST_HOLD];
            next_s.ctrl_tmp = pwdata_i[`FSP_CTRL_TMP_UNPROT];
          end
          next_s.prdata[`FSP_CTRL_RST_HOLD] = s.ctrl_rst;
          next_s.prdata[`FSP_CTRL_TMP_UNPROT] = s.ctrl_tmp;
        end
        `FSP_REG_ADDR: begin
          if (pwrite_i) begin
            next_s.reg_addr = pwdata_i[19:0];
          end
          next_s.prdata[19:0] = s.reg_addr;
        end
        `FSP_REG_DATA: begin
          if (pwrite_i) begin
            next_s.reg_data = pwdata_i[15:0];
          end
          next_s.prdata[15:0] = s.reg_data;
        end
        `FSP_REG_CMD: begin
          next_s.prdata[3:0] = s.op;
          if (pwrite_i && !s.busy) begin
            next_s.op = fsp_pkg::fsp_op_t'(pwdata_i[3:0]);
            next_s.refused = 1'b0;
            next_s.fail = 1'b0;
            next_s.not_acc = 1'b0;
            next_s.step = 3'h0;
            if (pwdata_i[3:0] > fsp_pkg::OP_VERIFY) begin
              next_s.refused = 1'b1;
            end else if (s.lock && !((pwdata_i[3:0] == fsp_pkg::OP_READ) ||
                (pwdata_i[3:0] == fsp_pkg::OP_POLL) ||
                (pwdata_i[3:0] == fsp_pkg::OP_RESET))) begin
              next_s.refused = 1'b1;
            end else begin
              next_s.busy = 1'b1;
            end
          end
        end
        `FSP_REG_STAT: begin
          next_s.prdata[`FSP_STAT_BUSY] = s.busy;
          next_s.prdata[`FSP_STAT_LOCK] = s.lock;
          next_s.prdata[`FSP_STAT_REFUSED] = s.refused;
          next_s.prdata[`FSP_STAT_FAIL] = s.fail;
          next_s.prdata[`FSP_STAT_NOT_ACC] = s.not_acc;
          next_s.prdata[`FSP_STAT_TOGGLING] = s.toggling;
          next_s.prdata[`FSP_STAT_EWIN] = s.ewin;
        end
        `FSP_REG_RDATA: begin
          next_s.prdata[15:0] = s.rdata;
        end
        default: begin
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    case (s.st)
      fsp_pkg::S_IDLE: begin
        if (s.busy) begin
          next_s.st = fsp_pkg::S_DISP;
        end
      end
      fsp_pkg::S_DISP: begin
        next_s.addr = cur.addr;
        next_s.ce_n = 1'b0;
        next_s.tload = 1'b1;
        if (cur.kind == fsp_pkg::K_W) begin
          // oe stays high through the whole write
          next_s.dout = cur.data;
          next_s.dq_oe_n = 1'b0;
          next_s.oe_n = 1'b1;
          next_s.tval = 22'(`FSP_SETUP_CYC);
          next_s.st = fsp_pkg::S_SETUP;
        end else if (cur.kind == fsp_pkg::K_R) begin
          next_s.dq_oe_n = 1'b1;
          next_s.oe_n = 1'b0;
          next_s.hv_a9 = (s.op == fsp_pkg::OP_VERIFY);
          next_s.tval = 22'(`FSP_ACC_CYC);
          next_s.st = fsp_pkg::S_RD;
        end else begin
          next_s.hv_a9 = 1'b1;
          next_s.hv_oe = 1'b1;
          next_s.tval = 22'(`FSP_VLHT_CYC);
          next_s.st = fsp_pkg::S_HVSET;
        end
      end
      fsp_pkg::S_SETUP: begin
        if (tok) begin
          next_s.we_n = 1'b0;
          next_s.tload = 1'b1;
          next_s.tval = 22'(`FSP_WE_CYC);
          next_s.st = fsp_pkg::S_WE;
        end
      end
      fsp_pkg::S_WE: begin
        if (tok) begin
          next_s.we_n = 1'b1;
          next_s.tload = 1'b1;
          next_s.tval = 22'(`FSP_WEH_CYC);
          next_s.st = fsp_pkg::S_WEH;
        end
      end
      fsp_pkg::S_WEH: begin
        if (tok) begin
          next_s.ce_n = 1'b1;
          next_s.dq_oe_n = 1'b1;
          next_s.st = fsp_pkg::S_STEP;
        end
      end
      fsp_pkg::S_RD: begin
        if (tok) begin
          next_s.rdata = dq_i;
          next_s.ewin = dq_i[`FSP_ERASE_WINDOW_FLAG_BIT];
          if (!s.step[0]) begin
            next_s.tog_prev = dq_i[`FSP_TOGGLE_FLAG_BIT];
          end
          next_s.oe_n = 1'b1;
          next_s.ce_n = 1'b1;
          next_s.hv_a9 = 1'b0;
          next_s.st = fsp_pkg::S_STEP;
        end
      end
      fsp_pkg::S_HVSET: begin
        if (tok) begin
          next_s.we_n = 1'b0;
          next_s.tload = 1'b1;
          next_s.tval = (s.op == fsp_pkg::OP_UNPROT) ? 22'(UNPROT_CYC) :
                        22'(`FSP_WPP1_CYC);
          next_s.st = fsp_pkg::S_HVPULSE;
        end
      end
      fsp_pkg::S_HVPULSE: begin
        if (tok) begin
          // pins keep their levels past the rising edge that ends programming
          next_s.we_n = 1'b1;
          next_s.tload = 1'b1;
          next_s.tval = 22'(`FSP_VLHT_CYC);
          next_s.st = fsp_pkg::S_HVREL;
        end
      end
      fsp_pkg::S_HVREL: begin
        if (tok) begin
          next_s.hv_a9 = 1'b0;
          next_s.hv_oe = 1'b0;
          next_s.ce_n = 1'b1;
          next_s.st = fsp_pkg::S_STEP;
        end
      end
      fsp_pkg::S_STEP: begin
        next_s.st = fsp_pkg::S_DISP;
        next_s.step = s.step + 3'h1;
        if (cur.last) begin
          next_s.busy = 1'b0;
          next_s.st = fsp_pkg::S_IDLE;
        end
        if (s.op == fsp_pkg::OP_RESET) begin
          next_s.lock = 1'b0;
        end
        if (s.op == fsp_pkg::OP_ERASE_ADD) begin
          if ((s.step == 3'h0) && s.ewin) begin
            next_s.refused = 1'b1;
            next_s.busy = 1'b0;
            next_s.st = fsp_pkg::S_IDLE;
          end
          if (s.step == 3'h2) begin
            next_s.not_acc = s.ewin;
          end
        end
        if ((s.op == fsp_pkg::OP_POLL) && s.step[0]) begin
          if (s.tog_prev == s.rdata[`FSP_TOGGLE_FLAG_BIT]) begin
            next_s.toggling = 1'b0;
            next_s.busy = 1'b0;
            next_s.st = fsp_pkg::S_IDLE;
          end else if (s.step == 3'h3) begin
            next_s.toggling = 1'b1;
            next_s.fail = 1'b1;
            next_s.lock = 1'b1;
          end else if (!s.rdata[`FSP_TIMEOUT_FLAG_BIT]) begin
            next_s.toggling = 1'b1;
            next_s.busy = 1'b0;
            next_s.st = fsp_pkg::S_IDLE;
          end
        end
      end
      default: begin
        next_s = RST_VAL;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= RST_VAL;
    end else if (clk_en_i) begin
      s <= next_s;
    end
  end

  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign addr_o = s.addr;
  assign dq_o = s.dout;
  assign dq_oe_n_o = s.dq_oe_n;
  assign ce_n_o = s.ce_n;
  assign oe_n_o = s.oe_n;
  assign we_n_o = s.we_n;
  assign rst_n_o = !s.ctrl_rst;
  assign hv_rst_o = s.ctrl_tmp;
  assign hv_a9_o = s.hv_a9;
  assign hv_oe_o = s.hv_oe;
  assign busy_o = s.busy;

  // write-strobe low time, counted for the pulse-width check below
  logic [7:0] we_low;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      we_low <= 8'h00;
    end else if (clk_en_i) begin
      we_low <= s.we_n ? 8'h00 : ((we_low == 8'hff) ? we_low : we_low + 8'h01);
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  chk_write_gating: assert property (!s.we_n && !s.hv_oe |-> s.oe_n && !s.ce_n)
    else $error("write strobe low without cs low and oe high");
  chk_write_drives_dq: assert property (!s.we_n && !s.hv_oe |-> !s.dq_oe_n)
    else $error("write strobe low while data bus released");
  chk_we_width: assert property (clk_en_i && !s.we_n && next_s.we_n && !s.hv_oe
      |-> we_low >= 8'(`FSP_WE_CYC))
    else $error("write pulse shorter than its minimum");
  chk_lock_reset_only: assert property (s.lock && !s.we_n
      |-> s.dout == `FSP_CMD_RESET)
    else $error("non-reset write issued while timeout lock is set");
  chk_protect_pins: assert property (s.hv_oe && !s.we_n |-> s.hv_a9 && !s.ce_n
      && (s.addr[`FSP_ADDRESS_BIT_SIX] == (s.op == fsp_pkg::OP_UNPROT)))
    else $error("protect pulse with wrong pin levels");
  chk_unprotect_a6: assert property (s.hv_oe && s.op == fsp_pkg::OP_UNPROT
      |-> s.addr[`FSP_ADDRESS_BIT_SIX])
    else $error("unprotect without address bit six high");
  chk_verify_read: assert property (s.hv_a9 && !s.oe_n
      |-> s.we_n && !s.ce_n && s.addr[`FSP_ADDRESS_BIT_ONE])
    else $error("protect verify read with wrong pin levels");
  chk_add_checked: assert property (s.op == fsp_pkg::OP_ERASE_ADD && !s.we_n
      |-> s.step == 3'h1 && !s.ewin)
    else $error("added sector erase written without a prior window check");
  chk_fail_locks: assert property (clk_en_i && !s.fail && next_s.fail
      |=> s.lock && s.toggling)
    else $error("poll failure did not set lock");
  chk_pready_pulse: assert property (s.pready && clk_en_i |=> !s.pready)
    else $error("pready held longer than one cycle");
endmodule : fsp_ctrl

// >>> hdl/fsp_map.svh
// fsp_map.svh: register offsets, bit positions, command codes and timing counts
// assumes a 250 MHz system clock and a 16-bit parallel flash outside
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH
`define FSP_REG_CTRL 8'h00
`define FSP_REG_ADDR 8'h04
`define FSP_REG_DATA 8'h08
`define FSP_REG_CMD 8'h0c
`define FSP_REG_STAT 8'h10
`define FSP_REG_RDATA 8'h14
`define FSP_CTRL_RST_HOLD 0
`define FSP_CTRL_TMP_UNPROT 1
`define FSP_STAT_BUSY 0
`define FSP_STAT_LOCK 1
`define FSP_STAT_REFUSED 2
`define FSP_STAT_FAIL 3
`define FSP_STAT_NOT_ACC 4
`define FSP_STAT_TOGGLING 5
`define FSP_STAT_EWIN 6
`define FSP_POLLING_FLAG_BIT 7
`define FSP_TOGGLE_FLAG_BIT 6
`define FSP_TIMEOUT_FLAG_BIT 5
`define FSP_ERASE_WINDOW_FLAG_BIT 3
`define FSP_ADDRESS_BIT_SIX 6
`define FSP_ADDRESS_BIT_ONE 1
`define FSP_UNLOCK1_ADDR 20'h00555
`define FSP_UNLOCK2_ADDR 20'h002aa
`define FSP_UNLOCK1_DATA 16'h00aa
`define FSP_UNLOCK2_DATA 16'h0055
`define FSP_CMD_PROG 16'h00a0
`define FSP_CMD_ERASE 16'h0080
`define FSP_CMD_SECTOR 16'h0030
`define FSP_CMD_ID 16'h0090
`define FSP_CMD_RESET 16'h00f0
`define FSP_CLK_MHZ 250
`define FSP_T_GLITCH_NS 5
`define FSP_T_WE_NS 55
`define FSP_T_WEH_NS 20
`define FSP_T_ACC_NS 70
`define FSP_T_VLHT_US 4
`define FSP_T_WPP1_US 10
`define FSP_T_WPP2_MS 12
`define FSP_SETUP_CYC 1
`define FSP_WE_CYC ((`FSP_T_WE_NS * `FSP_CLK_MHZ + 999) / 1000)
`define FSP_GLITCH_CYC ((`FSP_T_GLITCH_NS * `FSP_CLK_MHZ + 999) / 1000)
`define FSP_WEH_CYC ((`FSP_T_WEH_NS * `FSP_CLK_MHZ + 999) / 1000)
`define FSP_ACC_CYC ((`FSP_T_ACC_NS * `FSP_CLK_MHZ + 999) / 1000)
`define FSP_VLHT_CYC (`FSP_T_VLHT_US * `FSP_CLK_MHZ)
`define FSP_WPP1_CYC (`FSP_T_WPP1_US * `FSP_CLK_MHZ)
`define FSP_WPP2_CYC (`FSP_T_WPP2_MS * `FSP_CLK_MHZ * 1000)
`endif

// >>> hdl/fsp_pkg.sv
// fsp_pkg: types of the flash status and protection controller
// assumes fsp_map.svh supplies all numeric constants except the order, state and kind codes defined here
package fsp_pkg;
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_WRITE = 4'h1, OP_RESET = 4'h2, OP_PROG = 4'h3,
    OP_ERASE = 4'h4, OP_ERASE_ADD = 4'h5, OP_ID = 4'h6, OP_POLL = 4'h7,
    OP_PROTECT = 4'h8, OP_UNPROT = 4'h9, OP_VERIFY = 4'ha
  } fsp_op_t;
  typedef enum logic [9:0] {
    S_IDLE = 10'h001, S_DISP = 10'h002, S_SETUP = 10'h004, S_WE = 10'h008,
    S_WEH = 10'h010, S_RD = 10'h020, S_HVSET = 10'h040, S_HVPULSE = 10'h080,
    S_HVREL = 10'h100, S_STEP = 10'h200
  } fsp_state_t;
  typedef enum logic [1:0] {K_W = 2'h0, K_R = 2'h1, K_HV = 2'h2} fsp_kind_t;
  typedef struct packed {
    fsp_kind_t kind;
    logic last;
    logic [19:0] addr;
    logic [15:0] data;
  } fsp_step_t;
  typedef struct packed {
    fsp_state_t st;
    fsp_op_t op;
    logic [2:0] step;
    logic busy;
    logic lock;
    logic refused;
    logic fail;
    logic not_acc;
    logic toggling;
    logic ewin;
    logic tog_prev;
    logic ctrl_rst;
    logic ctrl_tmp;
    logic [19:0] reg_addr;
    logic [15:0] reg_data;
    logic [15:0] rdata;
    logic [19:0] addr;
    logic [15:0] dout;
    logic dq_oe_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic hv_a9;
    logic hv_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tload;
    logic [21:0] tval;
  } fsp_state_vec_t;
  typedef struct packed {
    logic [21:0] cnt;
    logic done;
  } fsp_timer_t;
endpackage : fsp_pkg

// >>> hdl/fsp_timer.sv
// fsp_timer: down counter that times strobe phases of the flash controller
// assumes load_i is a one-cycle pulse; done_o is low from the cycle after a load of a nonzero value
`timescale 1ns/1ps
module fsp_timer (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic load_i,
  input wire logic [21:0] val_i,
  output logic done_o
);
  fsp_pkg::fsp_timer_t s;
  fsp_pkg::fsp_timer_t next_s;

  always_comb begin
    next_s = s;
    if (load_i) begin
      next_s.cnt = val_i;
      next_s.done = (val_i == 22'h000000);
    end else if (s.cnt != 22'h000000) begin
      next_s.cnt = s.cnt - 22'h000001;
      next_s.done = (s.cnt == 22'h000001);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '{cnt: 22'h000000, done: 1'b1};
    end else if (clk_en_i) begin
      s <= next_s;
    end
  end

  assign done_o = s.done;
endmodule : fsp_timer

// >>> dv/fsp_flash_model.sv
// fsp_flash_model: behavioural parallel nor flash seen by the controller
// assumes one sector for all addresses; algorithm time is counted in status reads
`timescale 1ns/1ps
module fsp_flash_model #(
  parameter logic [15:0] ID_CODE = 16'h00c3  // arbitrary value
) (
  input wire logic [19:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic dq_oe_n_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic rst_n_i,
  input wire logic hv_rst_i,
  input wire logic hv_a9_i,
  input wire logic hv_oe_i,
  output logic [15:0] dq_o,
  output logic viol_o
);
  logic [15:0] mem [logic [19:0]];
  logic [15:0] ld = 16'h0;
  logic [1:0] h = 2'd0;
  logic pg = 0, idm = 0, ar = 0, er = 0, bad = 0, tg = 0, prot = 0;
  logic rdsel;
  int rem = 0, rc = 0;
  time tf = 0;
  initial dq_o = 16'h0;
  initial viol_o = 1'b0;
  assign rdsel = !ce_n_i && !oe_n_i && we_n_i;
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    if (d == 16'h00f0 && !pg) begin
      rem = 0; bad = 0; idm = 0;
    end else if (rem > 0 || bad) begin
    end else if (pg) begin
      pg = 0; ld = d; rc = 0; er = 0;
      if (mem.exists(a)) begin rem = 1 << 30; bad = 1; end
      else if (!prot || hv_rst_i) begin rem = 3; mem[a] = d; end
    end else if (ar && h == 2'd2 && d == 16'h0030) begin
      ar = 0; er = 1; rem = 8; rc = 0;
    end else if (h == 2'd2) begin
      pg = d == 16'h00a0; idm = d == 16'h0090; ar = d == 16'h0080;
    end
    h = (a == 20'h00555 && d == 16'h00aa) ? 2'd1 :
        (h == 2'd1 && a == 20'h002aa && d == 16'h0055) ? 2'd2 : 2'd0;
  endtask
  always @(negedge we_n_i) tf = $time;
  always @(negedge rst_n_i) begin
    rem = 0; bad = 0; idm = 0; h = 0; pg = 0;
  end
  always @(posedge we_n_i) begin
    if (!ce_n_i && (!hv_oe_i && (!oe_n_i || dq_oe_n_i) || $time - tf < 5))
      viol_o = 1'b1;
    if (!ce_n_i && hv_a9_i && hv_oe_i) prot = !addr_i[6];
    else if (!ce_n_i && oe_n_i && $time - tf >= 5) wr(addr_i, dq_i);
  end
  always @(posedge rdsel) begin
    #1;  // pins changed on the same clock edge settle first
    if (hv_a9_i || idm) dq_o = addr_i[1] ? {15'h0, prot} : ID_CODE;
    else if (rem > 0) begin
      dq_o = 16'h0;
      dq_o[7] = !er && !ld[7];
      dq_o[6] = tg;
      dq_o[5] = bad && rc >= 4;
      dq_o[3] = er && rc >= 2;
      tg = !tg; rc++; rem = bad ? rem : rem - 1;
      if (er && rem == 0) mem.delete();
    end else dq_o = mem.exists(addr_i) ? mem[addr_i] : 16'hffff;
  end
  // released bus shows a changed word, never the stale one
  always @(negedge rdsel) dq_o = {dq_o[14:0], ~dq_o[15]};
endmodule : fsp_flash_model

// >>> dv/fsp_ctrl_test.sv
// fsp_ctrl_test: self-checking bench driving the flash controller over apb
// assumes fsp_flash_model on the pins and a shortened unprotect pulse
`timescale 1ns/1ps
`include "fsp_map.svh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", n, e, a); end end
module fsp_ctrl_test;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd, rd, st;
  logic pready, perr, err, busy, ce_n, oe_n, we_n, rst_n, hv_rst, hv_a9, hv_oe, viol;
  logic c_oe_n;
  logic [19:0] fa, a0, a;
  logic [15:0] c_dq, f_dq, d;
  logic [15:0] exp_mem [logic [19:0]];
  int err_total = 0;
  int checks_done = 0;
  int seed = 9018;
  int i;
  fsp_ctrl #(.UNPROT_CYC(50)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(1'b1),
    .paddr_i(pa), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(pready), .pslverr_o(perr), .addr_o(fa), .dq_i(f_dq),
    .dq_o(c_dq), .dq_oe_n_o(c_oe_n), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n),
    .rst_n_o(rst_n), .hv_rst_o(hv_rst), .hv_a9_o(hv_a9), .hv_oe_o(hv_oe), .busy_o(busy));
  fsp_flash_model FLASH (.addr_i(fa), .dq_i(c_dq), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .rst_n_i(rst_n), .hv_rst_i(hv_rst), .hv_a9_i(hv_a9), .hv_oe_i(hv_oe),
    .dq_oe_n_i(c_oe_n), .dq_o(f_dq), .viol_o(viol));
  initial forever #2 sys_clk_i = ~sys_clk_i;
  task automatic print_verdict;
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] wd);
    pa <= ad;
    pwr <= w;
    pwd <= wd;
    psel <= 1'b1;
    @(posedge sys_clk_i);
    pen <= 1'b1;
    do begin
      @(posedge sys_clk_i);
    end while (pready !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge sys_clk_i);
  endtask : apb
  task automatic op(input logic [3:0] c, input logic [19:0] ad, input logic [15:0] wd);
    apb(`FSP_REG_ADDR, 1'b1, {12'h0, ad});
    apb(`FSP_REG_DATA, 1'b1, {16'h0, wd});
    apb(`FSP_REG_CMD, 1'b1, {28'h0, c});
    while (busy !== 1'b0) begin
      @(posedge sys_clk_i);
    end
    apb(`FSP_REG_STAT, 1'b0, 32'h0);
    st = rd;
    apb(`FSP_REG_RDATA, 1'b0, 32'h0);
  endtask : op
  task automatic poll_done;
    repeat (8) if (st[`FSP_STAT_TOGGLING] === 1'b1) op(4'h7, 20'h0, 16'h0);
  endtask : poll_done
  task automatic prog(input logic [19:0] ad, input logic [15:0] wd, input logic live);
    op(4'h3, ad, wd);
    op(4'h7, ad, 16'h0);
    if (live) begin
      exp_mem[ad] = wd;
      `CHK("toggling", 1'b1, st[`FSP_STAT_TOGGLING])
      `CHK("polling bit", ~wd[7], rd[7])
    end
    poll_done();
    op(4'h0, ad, 16'h0);
    `CHK("array word", exp_mem.exists(ad) ? exp_mem[ad] : 16'hffff, rd[15:0])
  endtask : prog
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    apb(`FSP_REG_STAT, 1'b0, 32'h0);
    `CHK("status after reset", 32'h0, rd)
    `CHK("idle pins", 7'b1111000, {ce_n, oe_n, we_n, rst_n, hv_rst, hv_a9, hv_oe})
    apb(8'h40, 1'b0, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    for (i = 0; i < 6; i++) begin
      a = {12'h0, 4'(i), 4'($random(seed))};
      d = 16'($random(seed));
      prog(a, d, 1'b1);
    end
    a0 = a;
    op(4'h3, a0, ~exp_mem[a0]);
    repeat (8) if (st[`FSP_STAT_LOCK] !== 1'b1) op(4'h7, a0, 16'h0);
    `CHK("timeout lock", 2'b11, {st[`FSP_STAT_FAIL], st[`FSP_STAT_LOCK]})
    op(4'h3, 20'h00080, 16'h1234);
    `CHK("refused in timeout", 1'b1, st[`FSP_STAT_REFUSED])
    op(4'h2, 20'h0, 16'h0);
    `CHK("lock cleared", 1'b0, st[`FSP_STAT_LOCK])
    prog(20'h00080, 16'h1234, 1'b1);
    op(4'h4, a0, 16'h0);
    op(4'h5, a0, 16'h0);
    `CHK("add erase open", 2'b00, {st[`FSP_STAT_REFUSED], st[`FSP_STAT_NOT_ACC]})
    op(4'h5, a0, 16'h0);
    `CHK("add erase closed", 1'b1, st[`FSP_STAT_REFUSED])
    op(4'h7, a0, 16'h0);
    `CHK("erase polling bit", 1'b0, rd[7])
    poll_done();
    exp_mem.delete();
    op(4'h0, a0, 16'h0);
    `CHK("erased word", 16'hffff, rd[15:0])
    op(4'h1, 20'h00030, 16'h5555);
    op(4'h0, 20'h00030, 16'h0);
    `CHK("lone write", 16'hffff, rd[15:0])
    op(4'hb, 20'h0, 16'h0);
    `CHK("invalid order", 1'b1, st[`FSP_STAT_REFUSED])
    op(4'h8, a0, 16'h0);
    op(4'ha, a0, 16'h0);
    `CHK("protect verify", 16'h0001, rd[15:0])
    prog(20'h00090, 16'h00ff, 1'b0);
    apb(`FSP_REG_CTRL, 1'b1, 32'h2);
    `CHK("temp unprotect pin", 1'b1, hv_rst)
    prog(20'h00090, 16'h00ff, 1'b1);
    apb(`FSP_REG_CTRL, 1'b1, 32'h0);
    op(4'h6, 20'h0, 16'h0);
    op(4'h0, 20'h00002, 16'h0);
    `CHK("id protect bit", 16'h0001, rd[15:0])
    op(4'h2, 20'h0, 16'h0);
    op(4'h9, a0, 16'h0);
    op(4'h6, 20'h0, 16'h0);
    op(4'h0, 20'h00002, 16'h0);
    `CHK("id after unprotect", 16'h0000, rd[15:0])
    op(4'h2, 20'h0, 16'h0);
    apb(`FSP_REG_CTRL, 1'b1, 32'h1);
    `CHK("flash reset pin", 1'b0, rst_n)
    apb(`FSP_REG_CTRL, 1'b1, 32'h0);
    `CHK("strobe misuse", 1'b0, viol)
    print_verdict();
  end
  initial begin
    #240000;
    err_total++;
    print_verdict();
  end
endmodule : fsp_ctrl_test
